// ===== common/i2c_port_pkg.sv
// Constants, carriers and state types for the two-wire slave port.
// Assumes a 100 MHz system clock; the bus clock comes from the master.
package i2c_port_pkg;

	// Own seven-bit bus address after power-up.
	localparam logic [6:0] SLAVE_ADDR = 7'h0d;

	// Command codes seen as the first byte of a write.
	localparam logic [7:0] CMD_BLK_WR = 8'ha0;
	localparam logic [7:0] CMD_BLK_RD = 8'ha1;
	localparam logic [7:0] CMD_PTR = 8'hb0;

	// Byte framing, reset values and the last-byte count.
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam logic [7:0] ONE_BYTE = 8'h01;

	// Write FIFO shape.
	localparam int WR_FIFO_DEPTH = 8;
	localparam int WR_FIFO_WIDTH = 16;

	// One register write leaving the port.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} reg_wr_t;

	// Bus phase of the port.
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RX = 5'h02,
		ST_ACK = 5'h04,
		ST_TX = 5'h08,
		ST_RACK = 5'h10
	} state_t;

	// Meaning of the next byte of a write transaction.
	typedef enum logic [6:0] {
		WM_CMD = 7'h01,
		WM_PTR = 7'h02,
		WM_SINGLE = 7'h04,
		WM_COUNT = 7'h08,
		WM_BDATA = 7'h10,
		WM_RCOUNT = 7'h20,
		WM_DONE = 7'h40
	} wmode_t;

	// Whole state of the port.
	typedef struct packed {
		logic [2:0] scl_sy;
		logic [2:0] sda_sy;
		state_t state;
		wmode_t wm;
		logic first;
		logic rw;
		logic blk_rd;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic [7:0] ptr;
		logic [7:0] wr_addr;
		logic [7:0] count;
		logic sda_oe;
		logic push;
		reg_wr_t push_data;
	} port_state_t;

	localparam port_state_t ST_RST = '{
		scl_sy: 3'h7, sda_sy: 3'h7, state: ST_IDLE, wm: WM_CMD,
		first: 1'b0, rw: 1'b0, blk_rd: 1'b0, bit_cnt: 4'h0,
		shift: 8'h00, ptr: PTR_RST, wr_addr: 8'h00, count: 8'h00,
		sda_oe: 1'b0, push: 1'b0, push_data: 16'h0000
	};

endpackage

// ===== rtl/byte_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock; full and empty are exact, no overwrite on full.
module byte_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Filling side.
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Draining side.
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] fill;
	logic do_wr;
	logic do_rd;

	// Handshakes are combinational so the producer sees space at once.
	assign in_ready_o = (fill != (AW+1)'(DEPTH));
	assign out_valid_o = (fill != '0);
	assign do_wr = in_valid_i & in_ready_o;
	assign do_rd = out_valid_o & out_ready_i;
	assign out_data_o = mem[rd_ptr];

	// Storage carries no reset; only the pointers define content.
	always_ff @(posedge clk_i) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	// Pointers wrap at the depth, which need not be a power of two.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (do_rd) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			if (do_wr && !do_rd) begin
				fill <= fill + 1'b1;
			end else if (do_rd && !do_wr) begin
				fill <= fill - 1'b1;
			end
		end
	end

endmodule

// ===== rtl/i2c_pointer_port.sv
// Two-wire bus slave port that reaches the device register space.
// Assumes scl_i and sda_i come straight from pins and that the register
// file answers reg_rdata_i for reg_addr_o within one system clock.
module i2c_pointer_port (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Bus pins; the data pin is open drain.
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Register read side.
	output logic [7:0] reg_addr_o,
	input wire logic [7:0] reg_rdata_i,
	// Register write side, through the FIFO.
	output logic wr_valid_o,
	input wire logic wr_ready_i,
	output i2c_port_pkg::reg_wr_t wr_data_o,
	// Status.
	output logic busy_o
);

	i2c_port_pkg::port_state_t st;
	i2c_port_pkg::port_state_t next_st;

	// Decoded bus events, all from second synchroniser stage onward.
	logic scl_now;
	logic scl_prev;
	logic sda_now;
	logic sda_prev;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic fifo_ready;
	logic [15:0] fifo_out;

	// Stage 0 is the first flop, read only by stage 1.
	assign scl_now = st.scl_sy[1];
	assign scl_prev = st.scl_sy[2];
	assign sda_now = st.sda_sy[1];
	assign sda_prev = st.sda_sy[2];

	// Clock edges and the two bus conditions.
	assign scl_rise = scl_now & ~scl_prev;
	assign scl_fall = ~scl_now & scl_prev;
	assign start_seen = scl_now & scl_prev & sda_prev & ~sda_now;
	assign stop_seen = scl_now & scl_prev & ~sda_prev & sda_now;

	// The pin is only ever pulled low; the enable carries the bit.
	assign sda_o = 1'b0;
	assign sda_oe_o = st.sda_oe;
	assign reg_addr_o = st.ptr;
	assign busy_o = ~st.state[0];

	// Next-state logic of the whole port.
	always_comb begin
		logic ack;
		ack = 1'b0;
		next_st = st;
		next_st.scl_sy = {st.scl_sy[1:0], scl_i};
		next_st.sda_sy = {st.sda_sy[1:0], sda_i};
		next_st.push = 1'b0;
		if (stop_seen) begin
			// A stop ends every transfer and forgets a pending block read.
			next_st.state = i2c_port_pkg::ST_IDLE;
			next_st.sda_oe = 1'b0;
			next_st.blk_rd = 1'b0;
		end else if (start_seen) begin
			// Also a repeated start; the command state is kept for it.
			next_st.state = i2c_port_pkg::ST_RX;
			next_st.first = 1'b1;
			next_st.bit_cnt = 4'h0;
			next_st.sda_oe = 1'b0;
		end else begin
			case (st.state)
				i2c_port_pkg::ST_IDLE: begin
					// Released and deaf until a start is seen.
					next_st.sda_oe = 1'b0;
				end
				i2c_port_pkg::ST_RX: begin
					if (scl_rise) begin
						next_st.shift = {st.shift[6:0], sda_now};
						next_st.bit_cnt = st.bit_cnt + 4'h1;
					end else if (scl_fall &&
						st.bit_cnt == i2c_port_pkg::BITS_PER_BYTE) begin
						next_st.bit_cnt = 4'h0;
						next_st.state = i2c_port_pkg::ST_ACK;
						if (st.first) begin
							next_st.first = 1'b0;
							if (st.shift[7:1] == i2c_port_pkg::SLAVE_ADDR) begin
								ack = 1'b1;
								next_st.rw = st.shift[0];
								if (!st.shift[0]) begin
									next_st.wm = i2c_port_pkg::WM_CMD;
									next_st.blk_rd = 1'b0;
								end
							end else begin
								next_st.state = i2c_port_pkg::ST_IDLE;
							end
						end else begin
							case (st.wm)
								i2c_port_pkg::WM_CMD: begin
									ack = 1'b1;
									if (st.shift == i2c_port_pkg::CMD_PTR) begin
										next_st.wm = i2c_port_pkg::WM_PTR;
									end else if (st.shift == i2c_port_pkg::CMD_BLK_WR) begin
										next_st.wm = i2c_port_pkg::WM_COUNT;
									end else if (st.shift == i2c_port_pkg::CMD_BLK_RD) begin
										next_st.wm = i2c_port_pkg::WM_RCOUNT;
									end else begin
										next_st.wr_addr = st.shift;
										next_st.wm = i2c_port_pkg::WM_SINGLE;
									end
								end
								i2c_port_pkg::WM_PTR: begin
									ack = 1'b1;
									next_st.ptr = st.shift;
									next_st.wm = i2c_port_pkg::WM_DONE;
								end
								i2c_port_pkg::WM_SINGLE: begin
									// A full FIFO refuses the byte with no acknowledge.
									if (fifo_ready) begin
										ack = 1'b1;
										next_st.push = 1'b1;
										next_st.push_data = {st.wr_addr, st.shift};
									end
									next_st.wm = i2c_port_pkg::WM_DONE;
								end
								i2c_port_pkg::WM_COUNT: begin
									ack = 1'b1;
									next_st.count = st.shift;
									if (st.shift == 8'h00) begin
										next_st.wm = i2c_port_pkg::WM_DONE;
									end else begin
										next_st.wm = i2c_port_pkg::WM_BDATA;
									end
								end
								i2c_port_pkg::WM_BDATA: begin
									if (fifo_ready) begin
										ack = 1'b1;
										next_st.push = 1'b1;
										next_st.push_data = {st.ptr, st.shift};
										next_st.ptr = st.ptr + 8'h01;
										next_st.count = st.count - 8'h01;
										if (st.count == i2c_port_pkg::ONE_BYTE) begin
											next_st.wm = i2c_port_pkg::WM_DONE;
										end
									end
								end
								i2c_port_pkg::WM_RCOUNT: begin
									// The count is kept; the master's no acknowledge ends it.
									ack = 1'b1;
									next_st.count = st.shift;
									next_st.blk_rd = 1'b1;
									next_st.wm = i2c_port_pkg::WM_DONE;
								end
								i2c_port_pkg::WM_DONE: begin
									ack = 1'b0;
								end
								default: begin
									next_st.wm = i2c_port_pkg::WM_DONE;
								end
							endcase
						end
						// Driven a few clocks after the fall, well before the rise.
						next_st.sda_oe = ack;
					end
				end
				i2c_port_pkg::ST_ACK: begin
					if (scl_fall) begin
						// The ninth pulse is over: release, or start sending.
						if (st.rw) begin
							next_st.shift = reg_rdata_i;
							next_st.sda_oe = ~reg_rdata_i[7];
							next_st.state = i2c_port_pkg::ST_TX;
						end else begin
							next_st.sda_oe = 1'b0;
							next_st.state = i2c_port_pkg::ST_RX;
						end
						next_st.bit_cnt = 4'h0;
					end
				end
				i2c_port_pkg::ST_TX: begin
					if (scl_rise) begin
						next_st.bit_cnt = st.bit_cnt + 4'h1;
					end else if (scl_fall) begin
						if (st.bit_cnt == i2c_port_pkg::BITS_PER_BYTE) begin
							next_st.sda_oe = 1'b0;
							next_st.state = i2c_port_pkg::ST_RACK;
						end else begin
							next_st.shift = {st.shift[6:0], 1'b0};
							next_st.sda_oe = ~st.shift[6];
						end
					end
				end
				i2c_port_pkg::ST_RACK: begin
					if (scl_rise) begin
						// The pointer moves early so read data settles by the fall.
						if (st.blk_rd) begin
							next_st.ptr = st.ptr + 8'h01;
						end
						next_st.first = sda_now;
					end else if (scl_fall) begin
						next_st.first = 1'b0;
						next_st.bit_cnt = 4'h0;
						if (!st.first) begin
							next_st.shift = reg_rdata_i;
							next_st.sda_oe = ~reg_rdata_i[7];
							next_st.state = i2c_port_pkg::ST_TX;
						end else begin
							next_st.state = i2c_port_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					next_st.state = i2c_port_pkg::ST_IDLE;
					next_st.sda_oe = 1'b0;
				end
			endcase
		end
	end

	// The whole port state in one register.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st <= i2c_port_pkg::ST_RST;
		end else begin
			st <= next_st;
		end
	end

	// Register writes queue here; a stalled consumer turns into no acknowledge.
	byte_fifo #(
		.WIDTH(i2c_port_pkg::WR_FIFO_WIDTH),
		.DEPTH(i2c_port_pkg::WR_FIFO_DEPTH)
	) u_wr_fifo (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(st.push),
		.in_ready_o(fifo_ready),
		.in_data_i(st.push_data),
		.out_valid_o(wr_valid_o),
		.out_ready_i(wr_ready_i),
		.out_data_o(fifo_out)
	);

	assign wr_data_o = fifo_out;

endmodule

// ===== tb/i2c_pointer_port_asserts.sv
// Checker for the two-wire slave port, bound to its top module.
// Assumes the bus pins are sampled directly on the system clock.
module i2c_pointer_port_asserts (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Bus pins.
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	// Write side and status.
	input wire logic wr_valid_o,
	input wire logic wr_ready_i,
	input wire i2c_port_pkg::reg_wr_t wr_data_o,
	input wire logic busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic p_scl;
	logic p_sda;
	logic adr;
	logic [3:0] nb;
	logic [7:0] sh;
	wire rs = scl_i && !p_scl;
	wire st = scl_i && p_scl && p_sda && !sda_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// Tracks the address byte so the answer can be judged from what the master sent.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			p_scl <= 1'b1;
			p_sda <= 1'b1;
			adr <= 1'b0;
			nb <= 4'h0;
			sh <= 8'h00;
		end else begin
			p_scl <= scl_i;
			p_sda <= sda_i;
			if (st) begin
				adr <= 1'b1;
				nb <= 4'h0;
			end else if (rs) begin
				nb <= nb + 4'h1;
				sh <= {sh[6:0], sda_i};
				if (nb == 4'h8)
					adr <= 1'b0;
			end
		end
	end
	sequence s_start;
		scl_i && p_scl && p_sda && !sda_i;
	endsequence
	sequence s_stop;
		scl_i && p_scl && !p_sda && sda_i;
	endsequence
	// The ninth clock rises after our own address has been shifted in.
	sequence s_own_addr_done;
		rs && adr && nb == 4'h8 && sh[7:1] == 7'h0d;
	endsequence
	AST_START_BUSY: assert property (s_start |-> ##[1:8] busy_o)
		else $error("port not busy after start");
	AST_STOP_IDLE: assert property (s_stop |-> ##[1:8] !busy_o)
		else $error("port still busy after stop");
	AST_OE_CLK_LOW: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("data drive changed with clock high");
	AST_ADDR_ACK: assert property (rs && adr && nb == 4'h8 |-> sda_oe_o == (sh[7:1] == 7'h0d))
		else $error("address answer wrong");
	AST_ADDR_QUIET: assert property (adr && nb < 4'h8 && scl_i |-> !sda_oe_o)
		else $error("port drove data during address bits");
	AST_IDLE_QUIET: assert property (!busy_o |-> !sda_oe_o)
		else $error("idle port drives data");
	AST_OPEN_DRAIN: assert property (sda_o == 1'b0)
		else $error("data output not low");
	AST_WR_STAND: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_data_o))
		else $error("pending write lost");
	// The high phase lasts eight system clocks, so the pull must last that long.
	AST_ACK_HOLD: assert property (s_own_addr_done |=> sda_oe_o [*8])
		else $error("acknowledge not held through the ninth pulse");
endmodule

// ===== tb/i2c_master_model.sv
// Bus master model: drives the clock pin and pulls the data wire low.
// Assumes a pull-up on the data wire; each step lasts four system clocks.
module i2c_master_model (
	// Clock.
	input wire logic clk_i,
	// Bus pins.
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// The clock pin rests high between frames.
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	// One quarter of a 160 ns bus period.
	task automatic q(input logic c, input logic d);
		scl_o <= c;
		sda_low_o <= d;
		repeat (4) @(posedge clk_i);
	endtask
	// The clock falls first so data never moves while it is high.
	task automatic bit1(input logic d, output logic r);
		q(1'b0, sda_low_o);
		q(1'b0, !d);
		q(1'b1, !d);
		r = sda_i;
		q(1'b1, !d);
	endtask
	// Start: the data wire falls while the clock is high.
	task automatic start_cond();
		q(1'b0, sda_low_o);
		q(1'b0, 1'b0);
		q(1'b1, 1'b0);
		q(1'b1, 1'b1);
	endtask
	// Stop: the data wire is pulled low under a low clock, then released with the clock high.
	task automatic stop_cond();
		q(1'b0, sda_low_o);
		q(1'b0, 1'b1);
		q(1'b1, 1'b1);
		q(1'b1, 1'b0);
	endtask
	// Eight bits MSB first, then the receiver's answer.
	task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--) bit1(d[i], r[i]);
		bit1(ak, a);
	endtask
endmodule

// ===== tb/i2c_pointer_port_tb_top.sv
// Bench for the two-wire slave port with a master model and a stallable register file.
// Assumes the design package is compiled first.
module i2c_pointer_port_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic rdy = 1'b1;
	logic scl;
	logic m_low;
	logic oe;
	logic sdo;
	logic vld;
	logic busy;
	logic [7:0] radr;
	logic [7:0] mem [256];
	i2c_port_pkg::reg_wr_t wdat;
	i2c_port_pkg::reg_wr_t got[$];
	int bad_count = 0;
	int checks = 0;
	// The port's own data value counts, so a port that drove high would not pull the wire.
	wire sda = !(m_low || (oe && !sdo));
	wire [7:0] rdat = mem[radr];
	i2c_master_model i_i2c_master_model (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
	i2c_pointer_port i_i2c_pointer_port (.clk_i(clk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda),
		.sda_o(sdo), .sda_oe_o(oe), .reg_addr_o(radr), .reg_rdata_i(rdat), .wr_valid_o(vld),
		.wr_ready_i(rdy), .wr_data_o(wdat), .busy_o(busy));
	// System clock, 100 MHz.
	initial begin
		forever #5 clk = !clk;
	end
	// The register file keeps every taken write.
	always @(posedge clk) begin
		if (vld && rdy) begin
			got.push_back(wdat);
			mem[wdat.addr] <= wdat.data;
		end
	end
	task automatic give_verdict();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// Sends a byte; an answer of 0 means acknowledged.
	task automatic wb(input logic [7:0] b, input logic e);
		logic [7:0] r;
		logic a;
		i_i2c_master_model.xfer(b, 1'b1, r, a);
		chk("ack", 16'(e), 16'(a));
	endtask
	// Receives a byte and answers with k.
	task automatic rb(input logic k, input logic [7:0] e);
		logic [7:0] r;
		logic a;
		i_i2c_master_model.xfer(8'hff, k, r, a);
		chk("read", 16'(e), 16'(r));
	endtask
	// Bounded wait for n writes; running out ends the run.
	task automatic drain(input int n);
		rdy <= 1'b1;
		for (int i = 0; i < 40 && got.size() < n; i++) @(posedge clk);
		chk("writes", 16'(n), 16'(got.size()));
		if (got.size() != n)
			give_verdict();
	endtask
	task automatic ptr(input logic [7:0] p);
		i_i2c_master_model.start_cond();
		wb(8'h1a, 1'b0);
		wb(8'hb0, 1'b0);
		wb(p, 1'b0);
		i_i2c_master_model.stop_cond();
	endtask
	task automatic sc_foreign();
		i_i2c_master_model.start_cond();
		wb(8'h1c, 1'b1);
		wb(8'h00, 1'b1);
		chk("busy", 16'h0, 16'(busy));
		i_i2c_master_model.stop_cond();
	endtask
	task automatic sc_single();
		i_i2c_master_model.start_cond();
		wb(8'h1a, 1'b0);
		wb(8'h42, 1'b0);
		wb(8'h99, 1'b0);
		wb(8'h77, 1'b1);
		i_i2c_master_model.stop_cond();
		drain(1);
		chk("wr", 16'h4299, got.pop_front());
	endtask
	task automatic sc_recv();
		ptr(8'h10);
		chk("pointer", 16'h10, 16'(radr));
		i_i2c_master_model.start_cond();
		wb(8'h1b, 1'b0);
		rb(1'b1, 8'h10 ^ 8'h5c);
		i_i2c_master_model.stop_cond();
		chk("pointer", 16'h10, 16'(radr));
	endtask
	// The write side stalls so the buffer fills and refuses the last two bytes.
	task automatic sc_blk_wr();
		rdy <= 1'b0;
		ptr(8'h20);
		i_i2c_master_model.start_cond();
		wb(8'h1a, 1'b0);
		wb(8'ha0, 1'b0);
		wb(8'h0a, 1'b0);
		for (int i = 0; i < 10; i++) wb(8'hc0 + 8'(i), 1'(i > 7));
		i_i2c_master_model.stop_cond();
		chk("pointer", 16'h28, 16'(radr));
		drain(8);
		for (int i = 0; i < 8; i++) chk("wr", {8'h20 + 8'(i), 8'hc0 + 8'(i)}, got.pop_front());
	endtask
	task automatic sc_blk_rd();
		ptr(8'h30);
		i_i2c_master_model.start_cond();
		wb(8'h1a, 1'b0);
		wb(8'ha1, 1'b0);
		wb(8'h03, 1'b0);
		i_i2c_master_model.start_cond();
		wb(8'h1b, 1'b0);
		for (int i = 0; i < 3; i++) rb(1'(i == 2), (8'h30 + 8'(i)) ^ 8'h5c);
		i_i2c_master_model.stop_cond();
		chk("pointer", 16'h33, 16'(radr));
	endtask
	// Reset, then each scenario in turn.
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5c;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		sc_foreign();
		sc_single();
		sc_recv();
		sc_blk_wr();
		sc_blk_rd();
		give_verdict();
	end
endmodule
bind i2c_pointer_port i2c_pointer_port_asserts i_i2c_pointer_port_asserts (.clk_i(clk_i),
	.rst_b_i(rst_b_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
	.wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_data_o(wr_data_o), .busy_o(busy_o));
